// ===== core/pdcf_pkg.sv
package pdcf_pkg;

  // ==========================================================
  // Register map and reset values
  localparam logic [7:0] REG_TRAIN_ADDR = 8'h82;
  localparam logic [9:0] TRAIN_RST      = 10'h3A6;

  // ==========================================================
  // Sync channel codes, 10-bit form; 8-bit mode sends bits 9:2
  localparam logic [9:0] CODE_BLACK = 10'h015;
  localparam logic [9:0] CODE_IMAGE = 10'h035;
  localparam logic [9:0] CODE_CRC   = 10'h059;
  localparam logic [9:0] CODE_TRAIN = 10'h3A6;
  localparam logic [9:0] CODE_LS    = 10'h0AA;
  localparam logic [9:0] CODE_LE    = 10'h12A;

  // ==========================================================
  // Checksum, test data and geometry constants
  localparam logic [9:0] POLY10     = 10'h24F;
  localparam logic [7:0] POLY8      = 8'h4D;
  localparam logic [9:0] WORD_MAX   = 10'h3FF;
  localparam logic [6:0] GS_KERNELS = 7'h50;
  localparam int         NCH        = 32;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LS   = 3'b001,
    ST_DATA = 3'b010,
    ST_CRC  = 3'b011,
    ST_LE   = 3'b100
  } pdcf_state_t;

  typedef enum logic [1:0] {
    SUB_NONE  = 2'b00,
    SUB_MONO  = 2'b01,
    SUB_COLOR = 2'b10,
    SUB_BIN   = 2'b11
  } pdcf_sub_t;

  typedef struct packed {
    logic [9:0] train_word;
    logic [9:0] test_word;
    logic       crc_seed;
    logic       eight_bit;
    logic       test_en;
    logic       test_inc;
    logic       prbs_en;
    logic       frame_test;
    logic       comp_bypass;
    logic       global_shutter;
    pdcf_sub_t  sub_mode;
    logic [6:0] line_kernels;
    logic [3:0] black_lines;
    logic       seq_en;
  } pdcf_cfg_t;

  localparam pdcf_cfg_t CFG_RST = '{train_word: TRAIN_RST, sub_mode: SUB_NONE, default: '0};

  // Word as placed on a channel: 8-bit mode drops the two LSBs
  function automatic logic [9:0] pdcf_fmt(input logic eight, input logic [9:0] w);
    return eight ? {2'h0, w[9:2]} : w;
  endfunction

endpackage

// ===== core/pdcf_formatter.sv
`timescale 1ns/1ns
module pdcf_formatter
  import pdcf_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic                  reg_wr,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  output logic      [15:0]           reg_rdata,
  input  wire logic [9:0]            test_word,
  input  wire logic                  crc_seed,
  input  wire logic                  eight_bit,
  input  wire logic                  test_en,
  input  wire logic                  test_inc,
  input  wire logic                  prbs_en,
  input  wire logic                  frame_test,
  input  wire logic                  comp_bypass,
  input  wire logic                  global_shutter,
  input  wire logic [1:0]            sub_mode,
  input  wire logic [6:0]            line_kernels,
  input  wire logic [3:0]            black_lines,
  input  wire logic                  seq_en,
  input  wire logic                  link_clk,
  input  wire logic                  frame_go,
  input  wire logic                  line_go,
  input  wire logic [127:0][9:0]     kern_pix,
  output logic                       kern_next,
  output logic                       line_black,
  output logic                       line_busy,
  output wire logic [NCH-1:0][9:0]   dch_word,
  output logic      [9:0]            sync_word
);

  // ==========================================================
  // Register side (core clock)
  logic [9:0]  train_r;
  pdcf_cfg_t   cfg_now;
  pdcf_cfg_t   held_r;
  logic        req_r;
  logic [2:0]  ack_s_r;
  logic        ack_lvl_r;
  logic        ack_lvl_l_r;

  // Training word register, written from the serial port
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      train_r   <= TRAIN_RST;
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      if (reg_wr && reg_addr == REG_TRAIN_ADDR) begin
        train_r <= reg_wdata[9:0];
      end
      reg_rdata <= (reg_addr == REG_TRAIN_ADDR) ? {6'h00, train_r} : 16'h0000;
    end
  end

  always_comb begin
    cfg_now = '{train_word: train_r, test_word: test_word, crc_seed: crc_seed,
                eight_bit: eight_bit, test_en: test_en, test_inc: test_inc,
                prbs_en: prbs_en, frame_test: frame_test, comp_bypass: comp_bypass,
                global_shutter: global_shutter, sub_mode: pdcf_sub_t'(sub_mode),
                line_kernels: line_kernels, black_lines: black_lines, seq_en: seq_en};
  end

  // Acknowledge back from the link side; first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_s_r   <= 3'h0;
      ack_lvl_r <= 1'b0;
    end else if (ce) begin
      ack_s_r <= {ack_s_r[1:0], ack_lvl_l_r};
      if (ack_s_r[1] == ack_s_r[2]) begin
        ack_lvl_r <= ack_s_r[2];
      end
    end
  end

  // Config word held still until the link side has taken it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_r <= CFG_RST;
      req_r  <= 1'b0;
    end else if (ce && req_r == ack_lvl_r && held_r != cfg_now) begin
      held_r <= cfg_now;
      req_r  <= ~req_r;
    end
  end

  // ==========================================================
  // Link side crossing
  logic [2:0]  req_s_r;
  logic [2:0]  ce_s_r;
  logic        ce_l_r;
  pdcf_cfg_t   cfg_l;

  // Toggle and clock enable pass three stages; change counts when 2 and 3 agree
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s_r     <= 3'h0;
      ack_lvl_l_r <= 1'b0;
      ce_s_r      <= 3'h0;
      ce_l_r      <= 1'b0;
      cfg_l       <= CFG_RST;
    end else begin
      req_s_r <= {req_s_r[1:0], req_r};
      ce_s_r  <= {ce_s_r[1:0], ce};
      if (ce_s_r[1] == ce_s_r[2]) begin
        ce_l_r <= ce_s_r[2];
      end
      if (req_s_r[1] == req_s_r[2] && req_s_r[2] != ack_lvl_l_r) begin
        cfg_l       <= held_r;
        ack_lvl_l_r <= req_s_r[2];
      end
    end
  end

  // ==========================================================
  // Line sequencer
  pdcf_state_t state_r;
  logic [6:0]  kcnt_r;
  logic        ph_r;
  logic [3:0]  blk_left_r;
  logic        is_blk_r;
  logic [6:0]  line_len;
  logic        test_on;
  logic        cyc_test;
  logic        crc_test;
  logic [9:0]  tword;

  assign line_len = (is_blk_r && cfg_l.global_shutter) ? GS_KERNELS : cfg_l.line_kernels;
  assign test_on  = cfg_l.prbs_en | cfg_l.test_en;
  assign cyc_test = test_on && (!cfg_l.frame_test || state_r == ST_DATA);
  assign crc_test = test_on && (cfg_l.prbs_en || !cfg_l.frame_test);

  // Black lines first, then one image line per line_go
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      kcnt_r     <= 7'h00;
      ph_r       <= 1'b0;
      blk_left_r <= 4'h0;
      is_blk_r   <= 1'b0;
      kern_next  <= 1'b0;
      line_black <= 1'b0;
      line_busy  <= 1'b0;
    end else if (ce_l_r) begin
      kern_next <= (state_r == ST_DATA) && !ph_r;
      unique case (state_r)
        ST_IDLE: begin
          if (frame_go) begin
            blk_left_r <= (cfg_l.black_lines == 4'h0) ? 4'h1 : cfg_l.black_lines;
            is_blk_r   <= 1'b1;
            state_r    <= ST_LS;
          end else if (blk_left_r != 4'h0) begin
            is_blk_r <= 1'b1;
            state_r  <= ST_LS;
          end else if (line_go) begin
            is_blk_r <= 1'b0;
            state_r  <= ST_LS;
          end
        end
        ST_LS: begin
          kcnt_r  <= 7'h00;
          ph_r    <= 1'b0;
          state_r <= ST_DATA;
        end
        ST_DATA: begin
          ph_r <= ~ph_r;
          if (ph_r) begin
            kcnt_r <= kcnt_r + 7'h01;
            if (kcnt_r + 7'h01 >= line_len) begin
              state_r <= ST_CRC;
            end
          end
        end
        ST_CRC: begin
          state_r <= ST_LE;
        end
        ST_LE: begin
          if (is_blk_r) begin
            blk_left_r <= blk_left_r - 4'h1;
          end
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      line_black <= is_blk_r;
      line_busy  <= state_r != ST_IDLE;
    end
  end

  // ==========================================================
  // Sync channel: timing codes only, never test data
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_word <= CODE_TRAIN;
    end else if (ce_l_r) begin
      if (!cfg_l.seq_en) begin
        sync_word <= pdcf_fmt(cfg_l.eight_bit, CODE_TRAIN);
      end else begin
        unique case (state_r)
          ST_LS:   sync_word <= pdcf_fmt(cfg_l.eight_bit, CODE_LS);
          ST_LE:   sync_word <= pdcf_fmt(cfg_l.eight_bit, CODE_LE);
          ST_CRC:  sync_word <= pdcf_fmt(cfg_l.eight_bit, CODE_CRC);
          ST_DATA: sync_word <= pdcf_fmt(cfg_l.eight_bit,
                                         is_blk_r ? CODE_BLACK : CODE_IMAGE);
          default: sync_word <= pdcf_fmt(cfg_l.eight_bit, CODE_TRAIN);
        endcase
      end
    end
  end

  // ==========================================================
  // Test word generator, shared by all data channels
  logic [9:0] inc_r;
  logic [9:0] prbs_r;
  logic       t_adv;

  assign tword = cfg_l.prbs_en ? prbs_r : (cfg_l.test_inc ? inc_r : cfg_l.test_word);
  assign t_adv = cyc_test || (state_r == ST_CRC && crc_test);

  // Generated at 10 bits always; 8-bit mode trims at the output
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      inc_r  <= 10'h000;
      prbs_r <= 10'h001;
    end else if (ce_l_r) begin
      if (!cfg_l.prbs_en) begin
        prbs_r <= cfg_l.test_word;
      end else if (t_adv) begin
        prbs_r <= {prbs_r[8:0], prbs_r[9] ^ prbs_r[6]};
      end
      if (!cfg_l.test_en || (cfg_l.frame_test && state_r == ST_LS)) begin
        inc_r <= cfg_l.test_word;
      end else if (t_adv) begin
        inc_r <= (inc_r == WORD_MAX) ? cfg_l.test_word : inc_r + 10'h001;
      end
    end
  end

  // ==========================================================
  // Data channels
  function automatic logic [6:0] pix_idx(input int c, input logic ph, input logic odd,
                                         input pdcf_sub_t m);
    logic [5:0] k;
    k = 6'(2 * c) | {5'h00, ph};
    unique case (m)
      SUB_NONE:  pix_idx = odd ? {1'b0, 6'h3F - k} : {1'b0, k};
      SUB_COLOR: pix_idx = {k[5:1], 1'b0, k[0]};
      default:   pix_idx = {k, 1'b0};
    endcase
  endfunction

  function automatic logic [9:0] crc_step(input logic [9:0] c, input logic [9:0] d,
                                          input logic eight);
    logic [9:0] r;
    logic [7:0] r8;
    r  = c;
    r8 = c[7:0];
    for (int i = 9; i >= 0; i--) begin
      r = {r[8:0], 1'b0} ^ ((r[9] ^ d[i]) ? POLY10 : 10'h000);
    end
    for (int i = 9; i >= 2; i--) begin
      r8 = {r8[6:0], 1'b0} ^ ((r8[7] ^ d[i]) ? POLY8 : 8'h00);
    end
    crc_step = eight ? {2'h0, r8} : r;
  endfunction

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [9:0] crc_r;
    logic [9:0] off_r;
    logic [9:0] dout_r;
    logic [9:0] px;
    logic [9:0] img;
    logic [9:0] word;
    logic [9:0] crc_w;

    assign px    = kern_pix[pix_idx(c, ph_r, kcnt_r[0], cfg_l.sub_mode)];
    assign img   = (is_blk_r || cfg_l.comp_bypass) ? px
                 : (px > off_r ? px - off_r : 10'h000);
    assign word  = cyc_test ? tword : img;
    assign crc_w = cfg_l.eight_bit ? {crc_r[7:0], 2'h0} : crc_r;
    assign dch_word[c] = dout_r;

    // Checksum over every data word of the line, black or image; still seeded at line start, but not updated while prbs_en is set
    always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
        crc_r <= 10'h000;
      end else if (ce_l_r) begin
        if (state_r == ST_LS) begin
          crc_r <= cfg_l.crc_seed ? WORD_MAX : 10'h000;
        end else if (state_r == ST_DATA && !cfg_l.prbs_en) begin
          crc_r <= crc_step(crc_r, word, cfg_l.eight_bit);
        end
      end
    end

    // Offset taken from the latest raw black word of this channel
    always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
        off_r <= 10'h000;
      end else if (ce_l_r && state_r == ST_DATA && is_blk_r) begin
        off_r <= px;
      end
    end

    // Output word: data, checksum, test or training
    always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
        dout_r <= TRAIN_RST;
      end else if (ce_l_r) begin
        if (state_r == ST_DATA) begin
          dout_r <= pdcf_fmt(cfg_l.eight_bit, word);
        end else if (state_r == ST_CRC) begin
          dout_r <= pdcf_fmt(cfg_l.eight_bit, crc_test ? tword : crc_w);
        end else if (cyc_test) begin
          dout_r <= pdcf_fmt(cfg_l.eight_bit, tword);
        end else begin
          dout_r <= pdcf_fmt(cfg_l.eight_bit, cfg_l.train_word);
        end
      end
    end
  end

  // ==========================================================
  // Checks
  logic [8:0] dcnt_r;

  // Data cycles of the current line
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      dcnt_r <= 9'h000;
    end else if (ce_l_r) begin
      dcnt_r <= (state_r == ST_DATA) ? dcnt_r + 9'h001 : 9'h000;
    end
  end

  a_crc_slot_sync: assert property (@(posedge link_clk) disable iff (!rst_n)
    ce_l_r && state_r == ST_CRC && cfg_l.seq_en |=>
      sync_word == pdcf_fmt($past(cfg_l.eight_bit), CODE_CRC))
    else $error("sync not checksum code in checksum slot");

  a_black_sync: assert property (@(posedge link_clk) disable iff (!rst_n)
    ce_l_r && state_r == ST_DATA && is_blk_r && cfg_l.seq_en |=>
      sync_word == pdcf_fmt($past(cfg_l.eight_bit), CODE_BLACK))
    else $error("black word not marked on sync");

  a_crc_seed: assert property (@(posedge link_clk) disable iff (!rst_n)
    ce_l_r && state_r == ST_LS |=> g_ch[0].crc_r == ($past(cfg_l.crc_seed) ? WORD_MAX : 10'h000))
    else $error("checksum not seeded at line start");

  a_idle_train: assert property (@(posedge link_clk) disable iff (!rst_n)
    ce_l_r && state_r == ST_IDLE && !test_on |=>
      dch_word[0] == pdcf_fmt($past(cfg_l.eight_bit), $past(cfg_l.train_word)))
    else $error("idle channel not sending training word");

  a_unframed_test: assert property (@(posedge link_clk) disable iff (!rst_n)
    ce_l_r && test_on && !cfg_l.frame_test && state_r != ST_DATA |=>
      dch_word[5] == pdcf_fmt($past(cfg_l.eight_bit), $past(tword)))
    else $error("unframed test data interrupted");

  a_gs_black_len: assert property (@(posedge link_clk) disable iff (!rst_n)
    ce_l_r && state_r == ST_CRC && is_blk_r && cfg_l.global_shutter |->
      dcnt_r == 9'd160)
    else $error("global black line not 80 kernels");

  a_black_first: assert property (@(posedge link_clk) disable iff (!rst_n)
    ce_l_r && state_r == ST_IDLE && frame_go |=> state_r == ST_LS && is_blk_r ##1
      state_r == ST_DATA)
    else $error("frame did not open with a black line");

  a_odd_kernel: assert property (@(posedge link_clk) disable iff (!rst_n)
    ce_l_r && state_r == ST_DATA && cfg_l.sub_mode == SUB_NONE && kcnt_r[0] && !ph_r
      && !test_on && (is_blk_r || cfg_l.comp_bypass) |=>
      dch_word[0] == pdcf_fmt($past(cfg_l.eight_bit), $past(kern_pix[63])))
    else $error("odd kernel not reversed");

  a_inc_step: assert property (@(posedge link_clk) disable iff (!rst_n)
    ce_l_r && cfg_l.test_en && cfg_l.test_inc && !cfg_l.prbs_en && t_adv
      && state_r != ST_LS && inc_r != WORD_MAX && $stable(cfg_l) |=>
      inc_r == $past(inc_r) + 10'h001)
    else $error("incrementing word did not step");

  c_black_line: cover property (@(posedge link_clk) disable iff (!rst_n)
    state_r == ST_LE && is_blk_r);
  c_image_crc: cover property (@(posedge link_clk) disable iff (!rst_n)
    state_r == ST_CRC && !is_blk_r);
  c_color_sub: cover property (@(posedge link_clk) disable iff (!rst_n)
    state_r == ST_DATA && cfg_l.sub_mode == SUB_COLOR);
  c_prbs_slot: cover property (@(posedge link_clk) disable iff (!rst_n)
    state_r == ST_CRC && cfg_l.prbs_en && cfg_l.frame_test);

endmodule

// ===== test/pdcf_rx_model.sv
`timescale 1ns/1ns
// ====
// Receiver model: rebuilds lines and checks every channel checksum
module pdcf_rx_model
  import pdcf_pkg::*;
(
  input wire logic                 link_clk,
  input wire logic                 rst_n,
  input wire logic                 eight_bit,
  input wire logic                 crc_seed,
  input wire logic [NCH-1:0][9:0]  dch_word,
  input wire logic [9:0]           sync_word
);
  logic [9:0] crc [NCH];
  logic [9:0] w [4];
  logic [9:0] cls;
  int         nwords;
  int         lines;
  int         blk_lines;
  int         crc_err;

  // Code as it appears in the current word width
  function automatic logic [9:0] cd(input logic [9:0] c);
    return eight_bit ? {2'h0, c[9:2]} : c;
  endfunction

  // Serial update, MSB first; narrow mode only uses the low byte
  function automatic logic [9:0] upd(input logic [9:0] c, input logic [9:0] d);
    logic fb;
    for (int b = 9; b >= 0; b--) begin
      if (eight_bit && b > 7) continue;
      fb = (eight_bit ? c[7] : c[9]) ^ d[b];
      if (eight_bit) c = {2'h0, c[6:0], 1'b0} ^ (fb ? {2'h0, POLY8} : 10'h000);
      else c = {c[8:0], 1'b0} ^ (fb ? POLY10 : 10'h000);
    end
    return c;
  endfunction

  // Window number is never decoded, only line start, class, checksum and line end codes
  always @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lines = 0;
      blk_lines = 0;
      crc_err = 0;
      nwords = 0;
    end else if (sync_word === cd(CODE_LS)) begin
      nwords = 0;
      for (int c = 0; c < NCH; c++) crc[c] = crc_seed ? cd(10'h3FF) : 10'h000;
    end else if (sync_word === cd(CODE_IMAGE) || sync_word === cd(CODE_BLACK)) begin
      cls = sync_word;
      if (nwords < 4) w[nwords] = dch_word[1];
      nwords++;
      for (int c = 0; c < NCH; c++) crc[c] = upd(crc[c], dch_word[c]);
    end else if (sync_word === cd(CODE_CRC)) begin
      for (int c = 0; c < NCH; c++) if (dch_word[c] !== crc[c]) crc_err++;
    end else if (sync_word === cd(CODE_LE)) begin
      lines++;
      if (cls === cd(CODE_BLACK)) blk_lines++;
    end
  end
endmodule

// ===== test/test_pdcf_formatter.sv
`timescale 1ns/1ns
module test_pdcf_formatter
  import pdcf_pkg::*;
;
  logic                clock, link_clk, rst_n, reg_wr, frame_go, line_go;
  logic [7:0]          reg_addr;
  logic [15:0]         reg_wdata, reg_rdata, rd;
  logic [9:0]          test_word, sync_word, a;
  logic                crc_seed, eight_bit, test_en, test_inc, prbs_en, frame_test;
  logic                comp_bypass, global_shutter, seq_en, kern_next, line_black, line_busy;
  logic [1:0]          sub_mode;
  logic [6:0]          line_kernels;
  logic [3:0]          black_lines;
  logic [127:0][9:0]   kern_pix;
  logic [NCH-1:0][9:0] dch_word;
  logic [2:0]          kidx;
  int                  err_total, samples_checked, cyc;
  // Channel 1 pixel index per mode: kernel 0 both phases, kernel 1 both phases
  logic [6:0]          ord [4][4] = '{'{2, 3, 61, 60}, '{4, 6, 4, 6}, '{4, 5, 4, 5},
                                      '{4, 6, 4, 6}};

  // ====
  // Clocks, unrelated in phase
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  // Kernel source: index in low bits so order is visible
  always_comb begin
    for (int i = 0; i < 128; i++) kern_pix[i] = {kidx, 7'(i)};
  end
  always @(posedge link_clk) if (kern_next === 1'b1) kidx <= kidx + 3'h1;

  pdcf_formatter i_pdcf_formatter (.clock(clock), .rst_n(rst_n), .ce(1'b1), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .test_word(test_word), .crc_seed(crc_seed), .eight_bit(eight_bit), .test_en(test_en),
    .test_inc(test_inc), .prbs_en(prbs_en), .frame_test(frame_test),
    .comp_bypass(comp_bypass), .global_shutter(global_shutter), .sub_mode(sub_mode),
    .line_kernels(line_kernels), .black_lines(black_lines), .seq_en(seq_en),
    .link_clk(link_clk), .frame_go(frame_go), .line_go(line_go), .kern_pix(kern_pix),
    .kern_next(kern_next), .line_black(line_black), .line_busy(line_busy),
    .dch_word(dch_word), .sync_word(sync_word));
  pdcf_rx_model i_pdcf_rx_model (.link_clk(link_clk), .rst_n(rst_n), .eight_bit(eight_bit),
    .crc_seed(crc_seed), .dch_word(dch_word), .sync_word(sync_word));

  // ====
  // Shared tasks
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("Checked %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task reg_write(input logic [7:0] ad, input logic [15:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = ad;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task reg_read(input logic [7:0] ad, output logic [15:0] d);
    @(negedge clock);
    reg_addr = ad;
    @(negedge clock);
    d = reg_rdata;
  endtask
  // Config crosses to the link side with a few cycles of lag
  task settle;
    repeat (24) @(negedge link_clk);
  endtask
  // Start a frame or a line, then wait for n more line ends
  task run(input logic fr, input int n);
    int t;
    int goal;
    goal = i_pdcf_rx_model.lines + n;
    @(negedge link_clk);
    if (fr) frame_go = 1'b1;
    else line_go = 1'b1;
    @(negedge link_clk);
    frame_go = 1'b0;
    line_go = 1'b0;
    t = 0;
    while (i_pdcf_rx_model.lines < goal && t < 1000) begin
      @(negedge link_clk);
      t++;
    end
    check(16'(t < 1000), 16'h0001);
    repeat (4) @(negedge link_clk);
  endtask

  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict;
    end
  end

  // ====
  // Main sequence
  initial begin
    {rst_n, reg_wr, frame_go, line_go, crc_seed, eight_bit, test_en, test_inc} = '0;
    {prbs_en, frame_test, global_shutter, sub_mode, black_lines} = '0;
    {reg_addr, reg_wdata, kidx, cyc, err_total, samples_checked} = '0;
    comp_bypass = 1'b1;
    seq_en = 1'b1;
    line_kernels = 7'h02;
    test_word = 10'h155;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    settle;
    reg_read(8'h82, rd);
    check(rd, 16'h03A6);
    eight_bit = 1'b1;
    settle;
    check(dch_word[3], 10'h0E9);
    reg_write(8'h82, 16'hFEB7);
    reg_read(8'h82, rd);
    check(rd, 16'h02B7);
    reg_read(8'h83, rd);
    check(rd, 16'h0000);
    settle;
    check(dch_word[3], 10'h0AD);
    run(1'b1, 1);
    check(i_pdcf_rx_model.blk_lines, 1);
    check(i_pdcf_rx_model.cls, 10'h005);
    check(i_pdcf_rx_model.nwords, 4);
    {eight_bit, crc_seed, global_shutter, black_lines} = {3'b011, 4'h2};
    settle;
    run(1'b1, 2);
    check(i_pdcf_rx_model.blk_lines, 3);
    check(i_pdcf_rx_model.nwords, 160);
    check(i_pdcf_rx_model.cls, CODE_BLACK);
    {crc_seed, global_shutter} = 2'b00;
    for (int s = 0; s < 4; s++) begin
      sub_mode = 2'(s);
      settle;
      run(1'b0, 1);
      check(i_pdcf_rx_model.cls, CODE_IMAGE);
      for (int j = 0; j < 4; j++) check(i_pdcf_rx_model.w[j][6:0], ord[s][j]);
    end
    {sub_mode, test_en, frame_test} = 4'b0011;
    settle;
    check(dch_word[0], 10'h2B7);
    run(1'b0, 1);
    check(i_pdcf_rx_model.w[1], 10'h155);
    frame_test = 1'b0;
    settle;
    check(dch_word[0], 10'h155);
    check(sync_word, CODE_TRAIN);
    eight_bit = 1'b1;
    settle;
    check(dch_word[0], 10'h055);
    {eight_bit, test_inc} = 2'b01;
    settle;
    a = dch_word[0];
    @(negedge link_clk);
    check(dch_word[0], (a == WORD_MAX) ? 10'h155 : a + 10'h001);
    prbs_en = 1'b1;
    settle;
    a = dch_word[0];
    @(negedge link_clk);
    check(16'(dch_word[0] != a), 16'h0001);
    check(i_pdcf_rx_model.crc_err, 0);
    give_verdict;
  end
endmodule
